//--- verilog/sac_pkg.sv
// Purpose: shared constants and types for the converter sequence controller
// Assumes: 50 MHz system clock
// Notes:   timing counts derive from named times
package sac_pkg;
    localparam int          SAC_RES_BITS        = 12;
    localparam int          SAC_SYS_FREQ_KHZ    = 50000;
    localparam int          SAC_OSC_FREQ_KHZ    = 4000;
    localparam int          SAC_CONV_TIME_NS    = 3700;
    // successive-approximation step period, one tick of the internal oscillator
    localparam int          SAC_OSC_DIV         = SAC_SYS_FREQ_KHZ / SAC_OSC_FREQ_KHZ;
    localparam int          SAC_CONV_MAX_CYC    = (SAC_CONV_TIME_NS * SAC_SYS_FREQ_KHZ) / 1000000;
    localparam logic [3:0]  SAC_BIT_TOP         = 4'hB;
    localparam logic [3:0]  SAC_BIT_ZERO        = 4'h0;
    localparam logic [11:0] SAC_MSB_MASK        = 12'h800;
    localparam logic [11:0] SAC_RESULT_RESET    = 12'h000;

    typedef enum logic [1:0] {
        SAC_SHUTDOWN = 2'b00,
        SAC_TRACK    = 2'b01,
        SAC_CONVERT  = 2'b10,
        SAC_READOUT  = 2'b11
    } sac_state_type;

    // analog front-end steering, one bundle
    typedef struct packed {
        logic powerUp;
        logic holdSample;
        logic channelTwo;
        logic compareStrobe;
    } sac_analog_type;

    // serial data pin as two signals
    typedef struct packed {
        logic dataOut;
        logic dataOutEn;
    } sac_dout_type;
endpackage

//--- verilog/sac_ctrl.sv
// Purpose: start-pin sequencing, successive approximation and serial readout
// Assumes: start pin and serial clock asynchronous; comparator result synchronous
// Notes:   no software registers; differential variant selected by parameter
`timescale 1ns/10ps

// Notes on behaviour
// - start rise powers up and tracks
// - start fall holds sample, starts conversion
// - data low during conversion, MSB after
// - MSB valid within 3.7 us
// - automatic shutdown keeps result for readout
// - shift on serial clock fall, MSB first
// - data pin released after last bit
// - single rise after full read: channel one/unipolar
// - early rise selects channel two/bipolar
// - differential: unipolar binary, bipolar two's complement
// - steps timed by internal oscillator only
// - any serial rate up to 8 MHz
// - twelve-bit result by successive approximation
// - single-ended results always straight binary
module sac_ctrl
    import sac_pkg::*;
#(
    parameter bit          DIFF_VARIANT = 1'b0,
    parameter int          RES_BITS     = SAC_RES_BITS
) (
    input  wire logic      clk_sys,
    input  wire logic      arst_n,
    input  wire logic      convertStartPin,
    input  wire logic      serialClockPin,
    input  wire logic      compareHigh,
    output sac_analog_type analogCtrl,
    output sac_dout_type   doutPin,
    output logic           bipolarMode
);
    logic [2:0]            startSync;
    logic [2:0]            sclkSync;
    logic                  startLevel;
    logic                  sclkLevel;
    sac_state_type         state;
    logic [3:0]            bitIndex;
    logic [3:0]            oscCount;
    logic [RES_BITS-1:0]   approx;
    logic [RES_BITS-1:0]   shiftReg;
    logic                  fullyRead;
    logic                  chanTwo;

    wire agreeStart = startSync[2] == startSync[1];
    wire agreeSclk  = sclkSync[2] == sclkSync[1];
    wire startRise  = agreeStart && startSync[1] && !startLevel;
    wire startFall  = agreeStart && !startSync[1] && startLevel;
    wire sclkFall   = agreeSclk && !sclkSync[1] && sclkLevel;
    wire oscTick    = oscCount == 4'(SAC_OSC_DIV - 1);
    wire [RES_BITS-1:0] trialBit = RES_BITS'(SAC_MSB_MASK) >> (SAC_BIT_TOP - bitIndex);
    wire [RES_BITS-1:0] keptCode = compareHigh ? approx : (approx & ~trialBit);
    wire [RES_BITS-1:0] nextTrial = (bitIndex == SAC_BIT_ZERO) ? keptCode
                                  : (keptCode | (trialBit >> 1));
    // bipolar codes leave as two's complement: flip the sign bit of offset binary
    wire flipSign = DIFF_VARIANT && chanTwo;
    wire [RES_BITS-1:0] finalCode = flipSign ? (nextTrial ^ RES_BITS'(SAC_MSB_MASK))
                                             : nextTrial;
    wire convDone   = state == SAC_CONVERT && oscTick && bitIndex == SAC_BIT_ZERO;
    wire lastShift  = sclkFall && state == SAC_READOUT && bitIndex == SAC_BIT_ZERO;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            startSync  <= 3'h0;
            sclkSync   <= 3'h0;
            startLevel <= 1'b0;
            sclkLevel  <= 1'b0;
        end else begin
            startSync  <= {startSync[1:0], convertStartPin};
            sclkSync   <= {sclkSync[1:0], serialClockPin};
            if (agreeStart) begin
                startLevel <= startSync[1];
            end
            if (agreeSclk) begin
                sclkLevel <= sclkSync[1];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state     <= SAC_SHUTDOWN;
            bitIndex  <= SAC_BIT_TOP;
            oscCount  <= 4'h0;
            approx    <= SAC_RESULT_RESET;
            shiftReg  <= SAC_RESULT_RESET;
            fullyRead <= 1'b1;
            chanTwo   <= 1'b0;
        end else begin
            oscCount <= oscTick ? 4'h0 : oscCount + 4'h1;
            if (startRise) begin
                state   <= SAC_TRACK;
                chanTwo <= !fullyRead || state == SAC_TRACK;
            end else if (startFall && state == SAC_TRACK) begin
                state    <= SAC_CONVERT;
                bitIndex <= SAC_BIT_TOP;
                approx   <= RES_BITS'(SAC_MSB_MASK);
                oscCount <= 4'h0;
                // a rise during conversion means the result was never read
                fullyRead <= 1'b0;
            end else if (state == SAC_CONVERT && oscTick) begin
                if (convDone) begin
                    state     <= SAC_READOUT;
                    shiftReg  <= finalCode;
                    bitIndex  <= SAC_BIT_TOP;
                    fullyRead <= 1'b0;
                end else begin
                    approx   <= nextTrial;
                    bitIndex <= bitIndex - 4'h1;
                end
            end else if (sclkFall && state == SAC_READOUT) begin
                shiftReg <= shiftReg << 1;
                if (lastShift) begin
                    state     <= SAC_SHUTDOWN;
                    fullyRead <= 1'b1;
                end else begin
                    bitIndex <= bitIndex - 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            analogCtrl  <= '0;
            doutPin     <= '0;
            bipolarMode <= 1'b0;
        end else begin
            analogCtrl.powerUp       <= state == SAC_TRACK || state == SAC_CONVERT;
            analogCtrl.holdSample    <= state == SAC_CONVERT;
            analogCtrl.channelTwo    <= chanTwo;
            analogCtrl.compareStrobe <= state == SAC_CONVERT && oscTick;
            bipolarMode              <= DIFF_VARIANT && chanTwo;
            // low from start rise through conversion, then result bits
            doutPin.dataOutEn <= state != SAC_SHUTDOWN;
            doutPin.dataOut   <= state == SAC_READOUT && shiftReg[RES_BITS-1];
        end
    end
endmodule

//--- bench/sac_ctrl_checker.sv
// Purpose: port assertions for sac_ctrl
// Assumes: bound to every sac_ctrl
// Notes: none
`timescale 1ns/10ps
module sac_ctrl_checker import sac_pkg::*; #(parameter bit DIFF_VARIANT = 1'b0) (
    input wire logic     clk_sys, arst_n, convertStartPin, bipolarMode,
    input wire sac_analog_type analogCtrl,
    input wire sac_dout_type   doutPin);
    wire pu = analogCtrl.powerUp, hd = analogCtrl.holdSample, c2 = analogCtrl.channelTwo;
    wire st = convertStartPin, sb = analogCtrl.compareStrobe, en = doutPin.dataOutEn;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_wake; $rose(st) && !hd |-> ##[3:6] pu; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_hold; $fell(st) && pu && !hd |-> ##[3:10] (hd || c2); endproperty
    a_hold: assert property (p_hold) else $error("no hold");
    property p_low; pu |-> en && !doutPin.dataOut; endproperty
    a_low: assert property (p_low) else $error("data not low");
    property p_conv; $rose(hd) ##12 hd |-> ##[118:168] !hd; endproperty
    a_conv: assert property (p_conv) else $error("conversion time");
    property p_shut; $fell(hd) && !st |-> !pu && en; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_step; sb && hd |=> !sb [*8] ##4 (sb || !hd); endproperty
    a_step: assert property (p_step) else $error("step spacing");
    property p_keep; hd |-> $stable(c2); endproperty
    a_keep: assert property (p_keep) else $error("channel moved");
    property p_mode; hd |-> bipolarMode == (DIFF_VARIANT && c2); endproperty
    a_mode: assert property (p_mode) else $error("bad mode");
    c_two: cover property ($rose(c2));
    c_bip: cover property ($rose(bipolarMode));
    c_done: cover property ($fell(en));
endmodule
bind sac_ctrl sac_ctrl_checker #(.DIFF_VARIANT(DIFF_VARIANT)) chk_u (.clk_sys(clk_sys),
    .arst_n(arst_n), .convertStartPin(convertStartPin), .bipolarMode(bipolarMode),
    .analogCtrl(analogCtrl), .doutPin(doutPin));

//--- bench/sac_host.sv
// Purpose: host and comparator model
// Assumes: 50 MHz clk_sys
// Notes: serial clock idles low
`timescale 1ns/10ps
module sac_host (input wire logic clk_sys, strobe, dataIn,
    output logic startPin, sclk, output wire logic compareHigh);
    logic [11:0] pat;
    logic [3:0]  idx;
    initial begin startPin = 1'b0; sclk = 1'b0; pat = 12'h000; idx = 4'hB; end
    // comparator answers one pattern bit per step
    assign compareHigh = pat[idx];
    always @(posedge clk_sys) if (strobe && idx != 4'h0) idx <= idx - 4'h1;
    task step(input int n); repeat (n) @(posedge clk_sys); #1; endtask
    task conv(input bit two, input logic [11:0] p);
        pat = p; idx = 4'hB; startPin = 1'b1;
        if (two) begin step(4); startPin = 1'b0; step(4); startPin = 1'b1; end
        step(80); startPin = 1'b0;
    endtask
    task rd(input int n, output logic [11:0] v);
        v = 12'h000;
        repeat (n) begin sclk = 1'b1; v = {v[10:0], dataIn}; step(3); sclk = 1'b0; step(5); end
    endtask
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench for sac_ctrl
// Assumes: differential variant
// Notes: data wire floats when released
`timescale 1ns/10ps
module tb;
    import sac_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, bip;
    wire logic start, sclk, cmpHigh, dataWire;
    sac_analog_type ac;
    sac_dout_type   dp;
    logic [11:0]    v;
    int miscompares = 0, tests_run = 0;
    assign dataWire = dp.dataOutEn ? dp.dataOut : 1'bz;
    always #10 clk_sys = ~clk_sys;
    sac_ctrl #(.DIFF_VARIANT(1'b1)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
        .convertStartPin(start), .serialClockPin(sclk), .compareHigh(cmpHigh),
        .analogCtrl(ac), .doutPin(dp), .bipolarMode(bip));
    sac_host h (.clk_sys(clk_sys), .strobe(ac.compareStrobe), .dataIn(dataWire),
        .startPin(start), .sclk(sclk), .compareHigh(cmpHigh));
    task chk(input logic [12:0] got, input logic [12:0] exp);
        tests_run++;
        if (got !== exp) begin miscompares++; $display("mismatch %0t got %h", $time, got); end
    endtask
    task test_done;
        if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task s_uni;
        h.conv(1'b0, 12'hA5C);
        h.step(185);
        chk({ac.powerUp, dp.dataOutEn}, 13'h1);
        h.rd(12, v);
        chk({ac.channelTwo, v}, {1'b0, 12'hA5C});
        h.step(4);
        chk(dp.dataOutEn, 13'h0);
    endtask
    task s_early;
        h.conv(1'b0, 12'h3C3);
        h.step(185);
        h.rd(5, v);
        chk(v, 13'h007);
        h.conv(1'b0, 12'h6A9);
        h.step(185);
        h.rd(12, v);
        chk({ac.channelTwo, v}, {1'b1, 12'hEA9});
    endtask
    task s_two;
        h.conv(1'b1, 12'h155);
        h.rd(3, v);
        chk(v, 13'h000);
        h.step(161);
        h.rd(12, v);
        chk({bip, v}, {1'b1, 12'h955});
    endtask
    initial begin
        h.step(4);
        arst_n = 1'b1;
        h.step(4);
        s_uni;
        s_early;
        s_two;
        s_uni;
        test_done;
    end
    initial begin #400000; miscompares++; test_done; end
endmodule
